// ---- logic/adc_port_cfg.svh ----
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ADC_CLK_NS 5
`define ADC_CONV_NS 8000
`define ADC_ACQ_NS 2000
`define ADC_CONV_CYC ((`ADC_CONV_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_ACQ_CYC ((`ADC_ACQ_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_SCLK_HALF_NS 20
`define ADC_SCLK_HALF_CYC ((`ADC_SCLK_HALF_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

// ----------------------------------------
// pins and reset values
// ----------------------------------------
`define ADC_WORD_BITS 16
`define ADC_PIN_SERIAL_OUT 8
`define ADC_PIN_SCLK 9
`define ADC_PIN_SYNC 10
`define ADC_PIN_RDERR 11
`define ADC_RESULT_RST 16'h0000
`define ADC_PIN_SYNC_RST 10'h0e0
`endif

// ---- logic/adc_port_pkg.sv ----
package adc_port_pkg;
  typedef enum logic [1:0] {ST_ACQ, ST_WAIT, ST_CONV} conv_state_e;
endpackage : adc_port_pkg

// ---- logic/adc_port.sv ----
`timescale 1ns/100ps
`include "adc_port_cfg.svh"
module adc_port #(
  parameter int unsigned CONV_CYC = `ADC_CONV_CYC,
  parameter int unsigned ACQ_CYC = `ADC_ACQ_CYC,
  parameter int unsigned SCLK_HALF_CYC = `ADC_SCLK_HALF_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_sclk,
  input wire logic i_reset,
  input wire logic i_power_down_request,
  input wire logic i_convert_request_n,
  input wire logic i_chip_select_n,
  input wire logic i_read_n,
  input wire logic i_serial_parallel_select,
  input wire logic i_external_clock_select,
  input wire logic i_clock_invert_select,
  input wire logic i_frame_sync_polarity_select,
  input wire logic i_read_mode_or_chain_input,
  input wire logic [15:0] i_conv_result,
  output logic o_busy,
  output logic [15:0] o_data,
  output logic [15:0] o_data_oe
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0] pin_meta_reg;
  logic [9:0] pin_sync_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta_reg <= `ADC_PIN_SYNC_RST;
      pin_sync_reg <= `ADC_PIN_SYNC_RST;
    end else begin
      pin_meta_reg <= {i_reset, i_power_down_request, i_convert_request_n,
                       i_chip_select_n, i_read_n, i_serial_parallel_select,
                       i_external_clock_select, i_clock_invert_select,
                       i_frame_sync_polarity_select, i_read_mode_or_chain_input};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic dev_reset;
  logic pwr_dn;
  logic cnv_n;
  logic out_en;
  logic ser;
  logic ext;
  logic inv;
  logic pol;
  logic rdc;
  assign dev_reset = pin_sync_reg[9];
  assign pwr_dn = pin_sync_reg[8];
  assign cnv_n = pin_sync_reg[7];
  assign out_en = !pin_sync_reg[6] && !pin_sync_reg[5];
  assign ser = pin_sync_reg[4];
  assign ext = pin_sync_reg[3];
  assign inv = pin_sync_reg[2];
  assign pol = pin_sync_reg[1];
  assign rdc = pin_sync_reg[0];

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  adc_port_pkg::conv_state_e state_reg;
  logic [15:0] cnt_reg;
  logic cnv_prev_reg;
  logic cnv_fall;
  logic acq_end;
  logic conv_start;
  logic conv_done;
  assign cnv_fall = cnv_prev_reg && !cnv_n;
  assign acq_end = (state_reg == adc_port_pkg::ST_ACQ) && (cnt_reg == 16'(ACQ_CYC - 1));
  assign conv_start = !dev_reset && !pwr_dn &&
                      ((acq_end && !cnv_n) ||
                       (state_reg == adc_port_pkg::ST_WAIT && cnv_fall));
  assign conv_done = !dev_reset && (state_reg == adc_port_pkg::ST_CONV) &&
                     (cnt_reg == 16'(CONV_CYC - 1));

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnv_prev_reg <= 1'b1;
    end else begin
      cnv_prev_reg <= cnv_n;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= adc_port_pkg::ST_ACQ;
      cnt_reg <= 16'h0000;
    end else if (dev_reset) begin
      state_reg <= adc_port_pkg::ST_ACQ;
      cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        adc_port_pkg::ST_ACQ: begin
          if (acq_end) begin
            cnt_reg <= 16'h0000;
            state_reg <= conv_start ? adc_port_pkg::ST_CONV : adc_port_pkg::ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        adc_port_pkg::ST_WAIT: begin
          // power-down only blocks the start, never a running conversion
          if (conv_start) begin
            state_reg <= adc_port_pkg::ST_CONV;
          end
        end
        adc_port_pkg::ST_CONV: begin
          if (conv_done) begin
            cnt_reg <= 16'h0000;
            state_reg <= adc_port_pkg::ST_ACQ;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // result latch and busy
  // ----------------------------------------
  logic [15:0] result_reg;
  logic res_tog_reg;
  logic busy_reg;
  logic res_pend;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_reg <= `ADC_RESULT_RST;
      res_tog_reg <= 1'b0;
    end else if (dev_reset) begin
      result_reg <= `ADC_RESULT_RST;
    end else if (conv_done) begin
      result_reg <= i_conv_result;
      // flip only once the link has taken the last word, so that two unread
      // results never cancel out in the toggle parity
      res_tog_reg <= res_pend ? res_tog_reg : !res_tog_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_reg <= 1'b0;
    end else if (dev_reset || conv_done) begin
      busy_reg <= 1'b0;
    end else if (conv_start) begin
      busy_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // internal clock serial shifter
  // ----------------------------------------
  logic int_mode;
  logic pend_reg;
  logic iact_reg;
  logic iph_reg;
  logic [2:0] idiv_reg;
  logic [3:0] ibit_reg;
  logic [15:0] ish_reg;
  logic istart;
  logic ihalf;
  assign int_mode = ser && !ext;
  assign istart = pend_reg && out_en && !iact_reg && int_mode;
  assign ihalf = idiv_reg == 3'(SCLK_HALF_CYC - 1);

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_reg <= 1'b0;
    end else if (dev_reset || !int_mode) begin
      pend_reg <= 1'b0;
    end else if (rdc ? conv_start : conv_done) begin
      pend_reg <= 1'b1;
    end else if (istart) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iact_reg <= 1'b0;
      iph_reg <= 1'b0;
      idiv_reg <= 3'h0;
      ibit_reg <= 4'h0;
      ish_reg <= 16'h0000;
    end else if (dev_reset || !int_mode || !out_en) begin
      iact_reg <= 1'b0;
      iph_reg <= 1'b0;
      idiv_reg <= 3'h0;
    end else if (istart) begin
      iact_reg <= 1'b1;
      ish_reg <= result_reg;
      ibit_reg <= 4'h0;
      idiv_reg <= 3'h0;
      iph_reg <= 1'b0;
    end else if (iact_reg) begin
      idiv_reg <= ihalf ? 3'h0 : idiv_reg + 3'h1;
      if (ihalf) begin
        iph_reg <= !iph_reg;
        if (iph_reg) begin
          ish_reg <= {ish_reg[14:0], 1'b0};
          ibit_reg <= ibit_reg + 4'h1;
          if (ibit_reg == 4'hf) begin
            iact_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // external clock link domain
  // ----------------------------------------
  // inverting the clock moves the update edge; the select is static config
  logic link_clk;
  assign link_clk = i_sclk ^ i_clock_invert_select;
  logic [15:0] lsh_reg;
  logic [4:0] lcnt_reg;
  logic ltog_reg;
  logic lsdo_reg;
  logic lread_reg;
  // result_reg and res_tog_reg are only read while stable; a clash with a
  // new result is exactly the lost-read case and restarts the word
  always_ff @(posedge link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lsh_reg <= 16'h0000;
      lcnt_reg <= 5'h10;
      ltog_reg <= 1'b0;
      lsdo_reg <= 1'b0;
    end else if (!i_chip_select_n) begin
      if (res_tog_reg != ltog_reg) begin
        ltog_reg <= res_tog_reg;
        lsdo_reg <= result_reg[15];
        lsh_reg <= {result_reg[14:0], i_read_mode_or_chain_input};
        lcnt_reg <= 5'h01;
      end else begin
        lsdo_reg <= lsh_reg[15];
        lsh_reg <= {lsh_reg[14:0], i_read_mode_or_chain_input};
        lcnt_reg <= (lcnt_reg == 5'h10) ? lcnt_reg : lcnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lread_reg <= 1'b0;
    end else if (!i_chip_select_n) begin
      lread_reg <= (res_tog_reg != ltog_reg) || (lcnt_reg < 5'h0f);
    end
  end

  a_link_gate: assert property (@(posedge link_clk) disable iff (!i_rst_b)
    i_chip_select_n |=> $stable(lcnt_reg) && $stable(lsdo_reg))
    else $error("link state moved while chip select high");

  // ----------------------------------------
  // link to system crossing
  // ----------------------------------------
  logic [2:0] xmeta_reg;
  logic [2:0] xsync_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      xmeta_reg <= 3'h0;
      xsync_reg <= 3'h0;
    end else begin
      xmeta_reg <= {ltog_reg, lread_reg, lsdo_reg};
      xsync_reg <= xmeta_reg;
    end
  end
  assign res_pend = res_tog_reg != xsync_reg[2];

  logic rderr_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rderr_reg <= 1'b0;
    end else begin
      rderr_reg <= conv_done && ser && ext && xsync_reg[1];
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic [15:0] data_next;
  logic [15:0] oe_next;
  always_comb begin
    data_next = result_reg;
    oe_next = {16{out_en}};
    if (ser) begin
      data_next[7:0] = 8'h00;
      oe_next[7:0] = 8'h00;
      data_next[`ADC_PIN_SERIAL_OUT] = ext ? xsync_reg[0] : ish_reg[15];
      data_next[`ADC_PIN_SCLK] = iph_reg ^ inv;
      oe_next[`ADC_PIN_SCLK] = out_en && !ext;
      data_next[`ADC_PIN_SYNC] = iact_reg ^ pol;
      oe_next[`ADC_PIN_SYNC] = out_en && !ext;
      data_next[`ADC_PIN_RDERR] = rderr_reg;
      oe_next[`ADC_PIN_RDERR] = out_en && ext;
    end
  end

  // bits 15:12 keep the parallel role whatever the mode select says
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= 16'h0000;
      o_data_oe <= 16'h0000;
      o_busy <= 1'b0;
    end else begin
      o_data <= data_next;
      o_data_oe <= oe_next;
      o_busy <= busy_reg;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence s_acq_low_go;
    acq_end && !cnv_n && !pwr_dn && !dev_reset;
  endsequence
  sequence s_conv_run;
    (state_reg == adc_port_pkg::ST_CONV)[*2];
  endsequence

  a_start_now: assert property (s_acq_low_go |=> s_conv_run)
    else $error("no immediate start with request low");
  a_wait_edge: assert property (
    (state_reg == adc_port_pkg::ST_WAIT) && !cnv_fall |=>
    state_reg != adc_port_pkg::ST_CONV)
    else $error("conversion began without falling edge");
  a_pwr_dn_block: assert property (
    pwr_dn && (state_reg != adc_port_pkg::ST_CONV) |=>
    state_reg != adc_port_pkg::ST_CONV)
    else $error("conversion began during power-down");
  a_busy_rise: assert property (conv_start |=> ##1 o_busy)
    else $error("busy did not follow conversion start");
  a_busy_latch: assert property (
    $fell(busy_reg) && !$past(dev_reset) |-> result_reg == $past(i_conv_result))
    else $error("busy fell without result latch");
  a_reset_abort: assert property (dev_reset |=> !busy_reg &&
    state_reg == adc_port_pkg::ST_ACQ)
    else $error("reset pin did not abort conversion");
  a_oe_gate: assert property (!out_en |=> o_data_oe == 16'h0000)
    else $error("drivers on without chip select and read");
  a_rderr_pulse: assert property (rderr_reg |=> !rderr_reg)
    else $error("read error pulse longer than one cycle");
  a_rderr_cause: assert property (
    conv_done && ser && ext && xsync_reg[1] |=> ##1 o_data[`ADC_PIN_RDERR])
    else $error("lost read not flagged");
  a_sync_level: assert property (
    int_mode && out_en && iact_reg |=> o_data[`ADC_PIN_SYNC] == !$past(pol))
    else $error("frame sync at wrong level during shift");

endmodule : adc_port

// ---- bench/adc_host_reader.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// host side serial reader, slave clocking
// ----------------------------------------
module adc_host_reader (
  input wire logic i_go,
  input wire logic i_inv,
  input wire logic [4:0] i_bits,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic [15:0] o_word,
  output logic o_done
);
  initial begin
    o_sclk = 1'b0;
    o_word = 16'h0000;
    o_done = 1'b0;
  end
  // clock stands at the invert level between frames, period 125 ns inside them
  always @(posedge i_go) begin
    o_done = 1'b0;
    o_sclk = i_inv;
    #31.3;
    for (int k = 0; k < i_bits; k++) begin
      o_sclk = !i_inv;
      #62.5;
      o_sclk = i_inv;
      o_word = {o_word[14:0], i_sdo};
      #62.5;
    end
    o_done = 1'b1;
  end
endmodule : adc_host_reader

// ---- bench/adc_port_tb.sv ----
`timescale 1ns/100ps
module adc_port_tb;
  localparam int CONV = 200;
  localparam int ACQ = 50;
  localparam int HALF = 2;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_sclk;
  logic i_reset = 1'b0;
  logic pwr_dn = 1'b0;
  logic req = 1'b1;
  logic cs = 1'b1;
  logic rd = 1'b1;
  logic ser = 1'b0;
  logic ext = 1'b0;
  logic pol = 1'b0;
  logic inv = 1'b0;
  logic rdc = 1'b0;
  logic [15:0] res = 16'h0000;
  logic o_busy;
  logic [15:0] o_data;
  logic [15:0] o_data_oe;
  logic go = 1'b0;
  logic [4:0] nbits = 5'h10;
  logic [15:0] word;
  logic done;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int flag_cnt = 0;
  int hi;
  int w;
  int base;
  logic [15:0] iword = 16'h0000;
  logic sck_prev;

  always #2.5 i_clock = ~i_clock;

  adc_port #(.CONV_CYC(CONV), .ACQ_CYC(ACQ), .SCLK_HALF_CYC(HALF)) dut_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_reset(i_reset),
    .i_power_down_request(pwr_dn), .i_convert_request_n(req), .i_chip_select_n(cs),
    .i_read_n(rd), .i_serial_parallel_select(ser), .i_external_clock_select(ext),
    .i_clock_invert_select(inv), .i_frame_sync_polarity_select(pol),
    .i_read_mode_or_chain_input(rdc), .i_conv_result(res), .o_busy(o_busy),
    .o_data(o_data), .o_data_oe(o_data_oe)
  );

  adc_host_reader host_u (
    .i_go(go), .i_inv(inv), .i_bits(nbits), .i_sdo(o_data[8]), .o_sclk(i_sclk),
    .o_word(word), .o_done(done)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask : tick

  // falling edge start, power-down optionally raised once busy is seen
  task automatic conv(input logic [15:0] val, input logic dn_mid);
    res = val;
    req = 1'b0;
    w = 0;
    while (o_busy !== 1'b1 && w < 20) begin
      tick(1);
      w++;
    end
    req = 1'b1;
    pwr_dn = dn_mid;
    hi = 0;
    while (o_busy === 1'b1 && hi < 1000) begin
      tick(1);
      hi++;
    end
    tick(ACQ + 5);
  endtask : conv

  task automatic pread(input logic [15:0] exp);
    rd = 1'b0;
    tick(4);
    chk(o_data_oe, 16'h0000);
    cs = 1'b0;
    tick(4);
    chk(o_data_oe, 16'hffff);
    chk(o_data, exp);
    cs = 1'b1;
    rd = 1'b1;
    tick(4);
    chk(o_data_oe, 16'h0000);
  endtask : pread

  task automatic sread(input logic [4:0] n);
    nbits = n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 1000) begin
      tick(1);
      w++;
    end
    tick(4);
  endtask : sread

  always @(negedge i_clock) begin
    cyc <= cyc + 1;
    if (o_data[11] === 1'b1 && ser === 1'b1) begin
      flag_cnt <= flag_cnt + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(3);
    i_rst_b = 1'b1;
    tick(1);
    chk({15'h0000, o_busy}, 16'h0000);
    tick(ACQ + 10);
    conv(16'ha5c3, 1'b0);
    chk(16'(hi), 16'(CONV));
    pread(16'ha5c3);
    // request held low: restart with no new edge
    res = 16'h0f0f;
    req = 1'b0;
    w = 0;
    while (o_busy !== 1'b1 && w < 20) begin
      tick(1);
      w++;
    end
    w = 0;
    while (o_busy !== 1'b0 && w < 400) begin
      tick(1);
      w++;
    end
    w = 0;
    while (o_busy !== 1'b1 && w < 400) begin
      tick(1);
      w++;
    end
    chk(16'(w > ACQ - 2 && w < ACQ + 8), 16'h0001);
    req = 1'b1;
    tick(30);
    i_reset = 1'b1;
    tick(5);
    chk({15'h0000, o_busy}, 16'h0000);
    i_reset = 1'b0;
    tick(ACQ + 10);
    pread(16'h0000);
    conv(16'h1234, 1'b1);
    chk(16'(hi), 16'(CONV));
    req = 1'b0;
    tick(CONV + ACQ);
    chk({15'h0000, o_busy}, 16'h0000);
    req = 1'b1;
    tick(5);
    pwr_dn = 1'b0;
    tick(5);
    // external clock serial read, then an aborted one
    ser = 1'b1;
    ext = 1'b1;
    conv(16'hc3a5, 1'b0);
    cs = 1'b0;
    rd = 1'b0;
    sread(5'h10);
    chk(word, 16'hc3a5);
    chk({o_data_oe[15:12], 3'h0, o_data_oe[9], 8'h00}, 16'hf000);
    chk({o_data[15:12], 12'h000}, 16'hc000);
    // a fresh word read only four bits deep, then lost to the next result
    conv(16'h96e1, 1'b0);
    sread(5'h04);
    chk({12'h000, word[3:0]}, 16'h0009);
    base = flag_cnt;
    conv(16'h5a0f, 1'b0);
    chk(16'(flag_cnt - base), 16'h0001);
    sread(5'h10);
    chk(word, 16'h5a0f);
    cs = 1'b1;
    rd = 1'b1;
    // inverted shift clock, changed only while chip select is high
    tick(2);
    inv = 1'b1;
    conv(16'h7e81, 1'b0);
    cs = 1'b0;
    rd = 1'b0;
    sread(5'h10);
    chk(word, 16'h7e81);
    cs = 1'b1;
    rd = 1'b1;
    tick(2);
    inv = 1'b0;
    // internal clock: read after conversion, then read during the next one
    ext = 1'b0;
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      rdc = p[0];
      tick(5);
      if (p == 0) begin
        conv(16'h3c3c, 1'b0);
      end else begin
        res = 16'h6996;
        req = 1'b0;
      end
      cs = 1'b0;
      rd = 1'b0;
      w = 0;
      while (o_data[10] !== ~pol && w < 20) begin
        tick(1);
        w++;
      end
      chk({15'h0000, o_data_oe[9]}, 16'h0001);
      chk({15'h0000, o_busy}, {15'h0000, p[0]});
      hi = 0;
      sck_prev = 1'b0;
      while (o_data[10] === ~pol && hi < 200) begin
        if (o_data[9] === 1'b1 && !sck_prev) begin
          iword = {iword[14:0], o_data[8]};
        end
        sck_prev = o_data[9];
        tick(1);
        hi++;
      end
      chk(16'(hi), 16'(32 * HALF));
      chk(iword, 16'h3c3c);
      cs = 1'b1;
      rd = 1'b1;
    end
    req = 1'b1;
    tick(5);
    end_sim();
  end
endmodule : adc_port_tb
